// *** design/bfs_top.sv ***
// Purpose: Two opposite-direction queues between ports A and B with port flags.
// Assumes: Port clocks and controls are pins, sampled on sys_clk_i.
// Notes: Flags of each port change only on that port's sampled rising clock edge.
`timescale 1ns/100ps
`include "bfs_regs.svh"

// ----------------------------------------------------------------------------
// Storage queue
// ----------------------------------------------------------------------------
module bfs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [0:DEPTH-1];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign push = in_valid_i & ~full;
  assign pop = out_ready_i & ~empty;
  assign out_data_o = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------------
module bfs_top (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire bfs_pkg::bfs_port_a_t port_a_i,
  input wire bfs_pkg::bfs_port_b_t port_b_i,
  output logic [`BFS_DATA_W-1:0] port_a_data_o,
  output logic [`BFS_DATA_W-1:0] port_b_data_o,
  output bfs_pkg::bfs_flags_t port_a_flags_o,
  output bfs_pkg::bfs_flags_t port_b_flags_o
);
  import bfs_pkg::*;

  localparam int SK1 = `BFS_SK1_CYC;
  localparam int SK2 = `BFS_SK2_CYC;
  localparam int DW = `BFS_DATA_W;
  localparam int CW = `BFS_CNT_W;

  // --------------------------------------------------------------------------
  // Pin sampling
  // --------------------------------------------------------------------------
  bfs_port_a_t pa_s1_r;
  bfs_port_a_t pa_r;
  bfs_port_b_t pb_s1_r;
  bfs_port_b_t pb_r;
  logic pa_clk_d_r;
  logic pb_clk_d_r;
  logic a_edge;
  logic b_edge;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      pa_s1_r <= '0;
      pa_r <= '0;
      pb_s1_r <= '0;
      pb_r <= '0;
      pa_clk_d_r <= 1'b0;
      pb_clk_d_r <= 1'b0;
    end
    else
    begin
      pa_s1_r <= port_a_i;
      pa_r <= pa_s1_r;
      pb_s1_r <= port_b_i;
      pb_r <= pb_s1_r;
      pa_clk_d_r <= pa_r.clk;
      pb_clk_d_r <= pb_r.clk;
    end
  end

  assign a_edge = pa_r.clk & ~pa_clk_d_r;
  assign b_edge = pb_r.clk & ~pb_clk_d_r;

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  bfs_flags_t flags_a_r;
  bfs_flags_t flags_b_r;
  bfs_width_t b_width;
  logic [1:0] b_last_idx;
  logic [1:0] b_wpc_r;
  logic [1:0] b_rpc_r;
  logic a_sel;
  logic b_sel;
  logic a_wr;
  logic a_rd;
  logic b_wr_piece;
  logic b_rd_piece;
  logic b_wr;
  logic b_rd;
  logic q1_in_ready;
  logic q1_out_valid;
  logic q2_in_ready;
  logic q2_out_valid;
  logic [DW-1:0] q1_out_data;
  logic [DW-1:0] q2_out_data;

  assign a_sel = a_edge & ~pa_r.cs_n & pa_r.en & ~pa_r.mbx;
  assign a_wr = a_sel & pa_r.dir & flags_a_r.full_flag_n & q1_in_ready;
  assign a_rd = a_sel & ~pa_r.dir & flags_a_r.empty_flag_n & q2_out_valid;

  assign b_width = bfs_width_t'(pb_r.width);
  assign b_last_idx = (b_width == BFS_W_WORD) ? `BFS_PIECE_LAST_WORD :
                      (b_width == BFS_W_BYTE) ? `BFS_PIECE_LAST_BYTE :
                      `BFS_PIECE_LAST_LONG;
  assign b_sel = b_edge & ~pb_r.cs_n & pb_r.en & ~pb_r.mbx & (b_width != BFS_W_MAIL);
  assign b_wr_piece = b_sel & pb_r.dir & flags_b_r.full_flag_n & q2_in_ready;
  assign b_rd_piece = b_sel & ~pb_r.dir &
                      ((b_rpc_r != 2'h0) | (flags_b_r.empty_flag_n & q1_out_valid));
  assign b_wr = b_wr_piece & (b_wpc_r == b_last_idx);
  assign b_rd = b_rd_piece & (b_rpc_r == 2'h0);

  // --------------------------------------------------------------------------
  // Port-B piece assembly and split
  // --------------------------------------------------------------------------
  logic [DW-1:0] b_asm_r;
  logic [DW-1:0] b_asm_nxt;
  logic [DW-1:0] b_hold_r;
  logic [DW-1:0] b_src;
  logic [DW-1:0] b_hold_nxt;
  logic [DW-1:0] b_bus;

  assign b_asm_nxt = (b_width == BFS_W_WORD) ? {b_asm_r[17:0], pb_r.data[17:0]} :
                     (b_width == BFS_W_BYTE) ? {b_asm_r[26:0], pb_r.data[8:0]} :
                     pb_r.data;
  assign b_src = (b_rpc_r == 2'h0) ? q1_out_data : b_hold_r;
  assign b_hold_nxt = (b_width == BFS_W_WORD) ? {b_src[17:0], 18'h00000} :
                      (b_width == BFS_W_BYTE) ? {b_src[26:0], 9'h000} :
                      b_src;
  assign b_bus = (b_width == BFS_W_WORD) ? {port_b_data_o[35:18], b_src[35:18]} :
                 (b_width == BFS_W_BYTE) ? {port_b_data_o[35:9], b_src[35:27]} :
                 b_src;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      b_wpc_r <= 2'h0;
      b_rpc_r <= 2'h0;
      b_asm_r <= '0;
      b_hold_r <= '0;
    end
    else
    begin
      if (b_wr_piece)
      begin
        b_wpc_r <= b_wr ? 2'h0 : b_wpc_r + 2'h1;
        b_asm_r <= b_asm_nxt;
      end
      if (b_rd_piece)
      begin
        b_rpc_r <= (b_rpc_r == b_last_idx) ? 2'h0 : b_rpc_r + 2'h1;
        b_hold_r <= b_hold_nxt;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Queues
  // --------------------------------------------------------------------------
  bfs_fifo #(
    .WIDTH(DW),
    .DEPTH(`BFS_QUEUE_DEPTH)
  ) a_to_b_queue (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(a_wr),
    .in_ready_o(q1_in_ready),
    .in_data_i(pa_r.data),
    .out_valid_o(q1_out_valid),
    .out_ready_i(b_rd),
    .out_data_o(q1_out_data)
  );

  bfs_fifo #(
    .WIDTH(DW),
    .DEPTH(`BFS_QUEUE_DEPTH)
  ) b_to_a_queue (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(b_wr),
    .in_ready_o(q2_in_ready),
    .in_data_i(b_asm_nxt),
    .out_valid_o(q2_out_valid),
    .out_ready_i(a_rd),
    .out_data_o(q2_out_data)
  );

  // --------------------------------------------------------------------------
  // Transfer counts and flag crossings
  // --------------------------------------------------------------------------
  logic [CW-1:0] q1_wr_cnt_r;
  logic [CW-1:0] q1_rd_cnt_r;
  logic [CW-1:0] q2_wr_cnt_r;
  logic [CW-1:0] q2_rd_cnt_r;
  logic [CW-1:0] q1_wr_nxt;
  logic [CW-1:0] q1_rd_nxt;
  logic [CW-1:0] q2_wr_nxt;
  logic [CW-1:0] q2_rd_nxt;
  logic [CW-1:0] x_src [0:3];
  logic x_edge [0:3];
  logic [CW-1:0] x_fe [0:3];
  logic [CW-1:0] x_al [0:3];

  assign q1_wr_nxt = q1_wr_cnt_r + CW'(a_wr);
  assign q1_rd_nxt = q1_rd_cnt_r + CW'(b_rd);
  assign q2_wr_nxt = q2_wr_cnt_r + CW'(b_wr);
  assign q2_rd_nxt = q2_rd_cnt_r + CW'(a_rd);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      q1_wr_cnt_r <= '0;
      q1_rd_cnt_r <= '0;
      q2_wr_cnt_r <= '0;
      q2_rd_cnt_r <= '0;
    end
    else
    begin
      q1_wr_cnt_r <= q1_wr_nxt;
      q1_rd_cnt_r <= q1_rd_nxt;
      q2_wr_cnt_r <= q2_wr_nxt;
      q2_rd_cnt_r <= q2_rd_nxt;
    end
  end

  // Reads of the A-to-B queue and writes of the B-to-A queue travel to port A.
  assign x_src[0] = q1_rd_cnt_r;
  assign x_src[1] = q2_wr_cnt_r;
  assign x_src[2] = q1_wr_cnt_r;
  assign x_src[3] = q2_rd_cnt_r;
  assign x_edge[0] = a_edge;
  assign x_edge[1] = a_edge;
  assign x_edge[2] = b_edge;
  assign x_edge[3] = b_edge;

  // An event enters the first of two owning-edge stages only if it is the skew time old.
  for (genvar g = 0; g < 4; g++)
  begin : g_cross
    logic [CW-1:0] dl_r [0:SK2-1];
    logic [CW-1:0] fe_s1_r;
    logic [CW-1:0] fe_s2_r;
    logic [CW-1:0] al_s1_r;
    logic [CW-1:0] al_s2_r;

    always_ff @(posedge sys_clk_i)
    begin
      if (!rstn_i)
      begin
        for (int k = 0; k < SK2; k++)
        begin
          dl_r[k] <= '0;
        end
        fe_s1_r <= '0;
        fe_s2_r <= '0;
        al_s1_r <= '0;
        al_s2_r <= '0;
      end
      else
      begin
        dl_r[0] <= x_src[g];
        for (int k = 1; k < SK2; k++)
        begin
          dl_r[k] <= dl_r[k-1];
        end
        if (x_edge[g])
        begin
          fe_s1_r <= dl_r[SK1-1];
          fe_s2_r <= fe_s1_r;
          al_s1_r <= dl_r[SK2-1];
          al_s2_r <= al_s1_r;
        end
      end
    end

    assign x_fe[g] = fe_s2_r;
    assign x_al[g] = al_s2_r;
  end

  // --------------------------------------------------------------------------
  // Flag evaluation
  // --------------------------------------------------------------------------
  logic [CW-1:0] a_q1_occ_fe;
  logic [CW-1:0] a_q1_occ_al;
  logic [CW-1:0] a_q2_occ_fe;
  logic [CW-1:0] a_q2_occ_al;
  logic [CW-1:0] b_q2_occ_fe;
  logic [CW-1:0] b_q2_occ_al;
  logic [CW-1:0] b_q1_occ_fe;
  logic [CW-1:0] b_q1_occ_al;
  bfs_flags_t flags_a_nxt;
  bfs_flags_t flags_b_nxt;

  assign a_q1_occ_fe = q1_wr_nxt - x_fe[0];
  assign a_q1_occ_al = q1_wr_nxt - x_al[0];
  assign a_q2_occ_fe = x_fe[1] - q2_rd_nxt;
  assign a_q2_occ_al = x_al[1] - q2_rd_nxt;
  assign b_q1_occ_fe = x_fe[2] - q1_rd_nxt;
  assign b_q1_occ_al = x_al[2] - q1_rd_nxt;
  assign b_q2_occ_fe = q2_wr_nxt - x_fe[3];
  assign b_q2_occ_al = q2_wr_nxt - x_al[3];

  assign flags_a_nxt.empty_flag_n = (a_q2_occ_fe != '0);
  assign flags_a_nxt.full_flag_n = (a_q1_occ_fe != `BFS_QUEUE_FULL);
  assign flags_a_nxt.almost_empty_flag_n = (a_q2_occ_al > `BFS_ALMOST_OFFSET);
  assign flags_a_nxt.almost_full_flag_n = (a_q1_occ_al < `BFS_ALMOST_FULL_AT);
  assign flags_b_nxt.empty_flag_n = (b_q1_occ_fe != '0);
  assign flags_b_nxt.full_flag_n = (b_q2_occ_fe != `BFS_QUEUE_FULL);
  assign flags_b_nxt.almost_empty_flag_n = (b_q1_occ_al > `BFS_ALMOST_OFFSET);
  assign flags_b_nxt.almost_full_flag_n = (b_q2_occ_al < `BFS_ALMOST_FULL_AT);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      flags_a_r <= `BFS_FLAGS_RST;
      flags_b_r <= `BFS_FLAGS_RST;
    end
    else
    begin
      if (a_edge)
      begin
        flags_a_r <= flags_a_nxt;
      end
      if (b_edge)
      begin
        flags_b_r <= flags_b_nxt;
      end
    end
  end

  assign port_a_flags_o = flags_a_r;
  assign port_b_flags_o = flags_b_r;

  // --------------------------------------------------------------------------
  // Read data with optional parity generation
  // --------------------------------------------------------------------------
  logic [DW-1:0] a_par;
  logic [DW-1:0] b_par;
  logic [DW-1:0] a_data_r;
  logic [DW-1:0] b_data_r;

  // Bit 8 of each byte becomes odd parity over the lower eight bits.
  for (genvar p = 0; p < 4; p++)
  begin : g_parity
    assign a_par[p*9 +: 9] = pa_r.pg ? {~^q2_out_data[p*9 +: 8], q2_out_data[p*9 +: 8]} :
                             q2_out_data[p*9 +: 9];
    assign b_par[p*9 +: 9] = pb_r.pg ? {~^b_bus[p*9 +: 8], b_bus[p*9 +: 8]} :
                             b_bus[p*9 +: 9];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      a_data_r <= '0;
      b_data_r <= '0;
    end
    else
    begin
      if (a_rd)
      begin
        a_data_r <= a_par;
      end
      if (b_rd_piece)
      begin
        b_data_r <= b_par;
      end
    end
  end

  assign port_a_data_o = a_data_r;
  assign port_b_data_o = b_data_r;
endmodule

// *** design/bfs_regs.svh ***
// Purpose: Constants for the bidirectional queue flag logic.
// Assumes: Included by the package and the design file.
// Notes: Times are in nanoseconds; cycle counts derive from the system clock.
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define BFS_DATA_W 36
`define BFS_CNT_W 7
`define BFS_QUEUE_DEPTH 64
`define BFS_QUEUE_FULL 7'h40
`define BFS_ALMOST_OFFSET 7'h08
`define BFS_ALMOST_FULL_AT 7'h38

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BFS_CLK_PERIOD_NS 50
`define BFS_SK1_NS 8
`define BFS_SK2_NS 16
`define BFS_SK1_CYC ((`BFS_SK1_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
`define BFS_SK2_CYC ((`BFS_SK2_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Reset values and last-piece indices
// ----------------------------------------------------------------------------
`define BFS_FLAGS_RST 4'h5
`define BFS_PIECE_LAST_LONG 2'h0
`define BFS_PIECE_LAST_WORD 2'h1
`define BFS_PIECE_LAST_BYTE 2'h3

`endif

// *** design/bfs_pkg.sv ***
// Purpose: Types shared by the bidirectional queue flag logic.
// Assumes: The constants header sits beside this file.
// Notes: Flag fields are active low, as on the pins.
package bfs_pkg;
  `include "bfs_regs.svh"

  typedef enum logic [1:0] {
    BFS_W_LONG = 2'b00,
    BFS_W_WORD = 2'b01,
    BFS_W_BYTE = 2'b10,
    BFS_W_MAIL = 2'b11
  } bfs_width_t;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic dir;
    logic mbx;
    logic en;
    logic pg;
    logic [`BFS_DATA_W-1:0] data;
  } bfs_port_a_t;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic dir;
    logic mbx;
    logic en;
    logic pg;
    logic [1:0] width;
    logic [`BFS_DATA_W-1:0] data;
  } bfs_port_b_t;

  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
  } bfs_flags_t;
endpackage

// *** verification/bfs_top_assertions.sv ***
// Purpose: Port-level checks for the bidirectional queue flag logic.
// Assumes: Bound to the top level; port clocks are seen through the pins.
// Notes: Flag and data changes must follow a rise of the owning port clock.
`timescale 1ns/100ps
`include "bfs_regs.svh"
module bfs_top_assertions (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire bfs_pkg::bfs_port_a_t port_a_i,
  input wire bfs_pkg::bfs_port_b_t port_b_i,
  input wire logic [35:0] port_a_data_o,
  input wire logic [35:0] port_b_data_o,
  input wire bfs_pkg::bfs_flags_t port_a_flags_o,
  input wire bfs_pkg::bfs_flags_t port_b_flags_o
);
  import bfs_pkg::*;
  logic ca_r;
  logic cb_r;
  logic [3:0] na_r;
  logic [3:0] nb_r;
  logic [3:0] na_nxt;
  logic [3:0] nb_nxt;
  // ----------------
  // Cycles since each port clock rose
  // ----------------
  assign na_nxt = (port_a_i.clk && !ca_r) ? 4'h0 : (na_r == 4'hF) ? na_r : na_r + 4'h1;
  assign nb_nxt = (port_b_i.clk && !cb_r) ? 4'h0 : (nb_r == 4'hF) ? nb_r : nb_r + 4'h1;
  always_ff @(posedge sys_clk_i)
  begin
    ca_r <= port_a_i.clk;
    cb_r <= port_b_i.clk;
    na_r <= rstn_i ? na_nxt : 4'hF;
    nb_r <= rstn_i ? nb_nxt : 4'hF;
  end
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------
  // Properties
  // ----------------
  a_rst_flags: assert property ($rose(rstn_i) |->
    port_a_flags_o == `BFS_FLAGS_RST && port_b_flags_o == `BFS_FLAGS_RST)
    else $error("flags not at reset value");
  a_rst_data: assert property ($rose(rstn_i) |->
    port_a_data_o == 36'h0 && port_b_data_o == 36'h0) else $error("data not cleared");
  a_a_flag_edge: assert property ($changed(port_a_flags_o) |-> na_r inside {[1:5]})
    else $error("port A flags moved off a port A edge");
  a_b_flag_edge: assert property ($changed(port_b_flags_o) |-> nb_r inside {[1:5]})
    else $error("port B flags moved off a port B edge");
  a_a_data_edge: assert property ($changed(port_a_data_o) |-> na_r inside {[1:5]})
    else $error("port A data moved off a port A edge");
  a_b_data_edge: assert property ($changed(port_b_data_o) |-> nb_r inside {[1:5]})
    else $error("port B data moved off a port B edge");
  a_a_empty_almost: assert property (!port_a_flags_o.empty_flag_n |->
    !port_a_flags_o.almost_empty_flag_n) else $error("port A empty without almost empty");
  a_a_full_almost: assert property (!port_a_flags_o.full_flag_n |->
    !port_a_flags_o.almost_full_flag_n) else $error("port A full without almost full");
  a_b_empty_almost: assert property (!port_b_flags_o.empty_flag_n |->
    !port_b_flags_o.almost_empty_flag_n) else $error("port B empty without almost empty");
  a_b_full_almost: assert property (!port_b_flags_o.full_flag_n |->
    !port_b_flags_o.almost_full_flag_n) else $error("port B full without almost full");
  cover property (!port_a_flags_o.full_flag_n);
  cover property (!port_b_flags_o.full_flag_n);
  cover property ($rose(port_a_flags_o.empty_flag_n));
endmodule

bind bfs_top bfs_top_assertions u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .port_a_i(port_a_i), .port_b_i(port_b_i), .port_a_data_o(port_a_data_o),
  .port_b_data_o(port_b_data_o), .port_a_flags_o(port_a_flags_o),
  .port_b_flags_o(port_b_flags_o));

// *** verification/bfs_port_b_model.sv ***
// Purpose: Port-B party with a free-running port clock.
// Assumes: The bench calls acc one access at a time.
// Notes: Released data lines carry the inverse of the last value.
`timescale 1ns/100ps
module bfs_port_b_model (
  input wire logic sys_clk_i,
  output bfs_pkg::bfs_port_b_t port_b_o
);
  import bfs_pkg::*;
  logic [2:0] ph_r = 3'h0;
  // ----------------
  // Clock and access
  // ----------------
  initial
  begin
    port_b_o = '0;
    port_b_o.cs_n = 1'b1;
  end
  // The clock is high three system cycles and low five.
  always @(negedge sys_clk_i)
  begin
    ph_r <= ph_r + 3'h1;
    port_b_o.clk <= (ph_r == 3'h7) || (ph_r < 3'h2);
  end
  // Controls are set two cycles before the rise and held through the high phase.
  task automatic acc(input logic dir, input logic [1:0] w, input logic [35:0] d,
    input logic pg);
    do @(negedge sys_clk_i); while (ph_r != 3'h5);
    port_b_o = '{port_b_o.clk, 1'b0, dir, 1'b0, 1'b1, pg, w, d};
    repeat (5) @(negedge sys_clk_i);
    port_b_o.cs_n = 1'b1;
    port_b_o.data = ~d;
    repeat (3) @(negedge sys_clk_i);
  endtask
endmodule

// *** verification/bidirectional_fifo_flag_sync_tb_top.sv ***
// Purpose: Self-checking bench for the bidirectional queue flag logic.
// Assumes: Port B is driven by its model; port A is driven here.
// Notes: Flags are compared once both port clocks have had time to settle them.
`timescale 1ns/100ps
`include "bfs_regs.svh"
module bidirectional_fifo_flag_sync_tb_top;
  import bfs_pkg::*;
  typedef struct {
    int sel;
    logic [35:0] e;
    logic [35:0] m;
    string nm;
  } bfs_note_t;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  bfs_port_a_t pa = '0;
  bfs_port_b_t pb;
  logic [35:0] a_dat;
  logic [35:0] b_dat;
  bfs_flags_t a_fl;
  bfs_flags_t b_fl;
  bfs_note_t notes[$];
  logic [35:0] ab_q[$];
  logic [35:0] ba_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h3317;
  int occ_ab = 0;
  int occ_ba = 0;
  logic [2:0] ph = 3'h0;
  event chk;
  // ----------------
  // Harness
  // ----------------
  bfs_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .port_a_i(pa), .port_b_i(pb),
    .port_a_data_o(a_dat), .port_b_data_o(b_dat), .port_a_flags_o(a_fl),
    .port_b_flags_o(b_fl));
  bfs_port_b_model pbm (.sys_clk_i(sys_clk_i), .port_b_o(pb));
  always #25 sys_clk_i = ~sys_clk_i;
  // Port A clock is high three cycles and low four, unrelated to port B.
  always @(negedge sys_clk_i)
  begin
    ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
    pa.clk <= (ph == 3'h6) || (ph < 3'h2);
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      close_out();
    end
  end
  always @(chk)
  begin : mon
    bfs_note_t n;
    logic [35:0] act;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      act = (n.sel == 0) ? a_dat : (n.sel == 1) ? b_dat : (n.sel == 2) ? {32'h0, a_fl}
        : {32'h0, b_fl};
      n_tests++;
      if ((act & n.m) !== (n.e & n.m))
      begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", n.nm, n.e & n.m, act & n.m);
      end
    end
  end
  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction
  function automatic logic [35:0] par(logic [35:0] d);
    for (int k = 0; k < 4; k++)
      d[9 * k + 8] = ~^d[9 * k +: 8];
    return d;
  endfunction
  function automatic logic [3:0] fl(int e, int f);
    return {e != 0, f != `BFS_QUEUE_FULL, e > `BFS_ALMOST_OFFSET, f < `BFS_ALMOST_FULL_AT};
  endfunction
  function automatic int npc(logic [1:0] w);
    return (w == 2'b00) ? 1 : (w == 2'b01) ? 2 : 4;
  endfunction
  task automatic note(int s, logic [35:0] e, logic [35:0] m, string nm);
    notes.push_back('{s, e, m, nm});
  endtask
  task automatic settle(string nm);
    repeat (36) @(negedge sys_clk_i);
    note(2, {32'h0, fl(occ_ba, occ_ab)}, 36'hF, {nm, " a flags"});
    note(3, {32'h0, fl(occ_ab, occ_ba)}, 36'hF, {nm, " b flags"});
    -> chk;
  endtask
  task automatic pa_acc(logic dir, logic [35:0] d, logic pg);
    do @(negedge sys_clk_i); while (ph != 3'h4);
    pa = '{pa.clk, 1'b0, dir, 1'b0, 1'b1, pg, d};
    repeat (5) @(negedge sys_clk_i);
    pa.cs_n = 1'b1;
    pa.data = ~d;
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic a_wr(logic [35:0] d);
    pa_acc(1'b1, d, 1'b0);
    if (occ_ab < 64)
    begin
      ab_q.push_back(d);
      occ_ab++;
    end
  endtask
  task automatic a_rd();
    logic [35:0] d;
    logic pg;
    d = ba_q.pop_front();
    occ_ba--;
    pg = 1'($random(seed));
    pa_acc(1'b0, rnd(), pg);
    note(0, pg ? par(d) : d, {36{1'b1}}, "a data");
    -> chk;
  endtask
  task automatic b_wr(logic [1:0] w, logic [35:0] d);
    int pw;
    pw = 36 / npc(w);
    for (int i = 0; i < npc(w); i++)
      pbm.acc(1'b1, w, d >> (36 - pw * (i + 1)), 1'b0);
    if (occ_ba < 64)
    begin
      ba_q.push_back(d);
      occ_ba++;
    end
  endtask
  task automatic b_rd(logic [1:0] w);
    logic [35:0] d;
    logic [35:0] p;
    logic pg;
    int pw;
    pw = 36 / npc(w);
    d = ab_q.pop_front();
    occ_ab--;
    for (int i = 0; i < npc(w); i++)
    begin
      pg = 1'($random(seed));
      p = d >> (36 - pw * (i + 1));
      pbm.acc(1'b0, w, rnd(), pg);
      note(1, pg ? par(p) : p, (36'h1 << pw) - 36'h1, "b data");
      -> chk;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    pa.cs_n = 1'b1;
    repeat (16) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    settle("reset");
    $display("test reset done");
    for (int i = 1; i <= 65; i++)
    begin
      a_wr(rnd());
      if (i inside {1, 8, 9, 55, 56, 64, 65})
        settle("fill ab");
    end
    $display("test fill_ab done");
    pbm.acc(1'b0, 2'b11, rnd(), 1'b0);
    note(1, 36'h0, {36{1'b1}}, "b mailbox idle");
    -> chk;
    for (int i = 0; i < 64; i++)
    begin
      b_rd(2'(i % 3));
      if (i inside {0, 7, 8, 54, 55, 63})
        settle("drain ab");
    end
    $display("test drain_ab done");
    for (int i = 0; i < 65; i++)
    begin
      b_wr((i == 64) ? 2'b00 : 2'(i % 3), rnd());
      if (i inside {0, 7, 8, 54, 55, 63, 64})
        settle("fill ba");
    end
    $display("test fill_ba done");
    for (int i = 0; i < 64; i++)
    begin
      a_rd();
      if (i inside {0, 7, 8, 54, 55, 63})
        settle("drain ba");
    end
    $display("test drain_ba done");
    close_out();
  end
endmodule
